// *** verif/bbf_exec_tb.sv ***
/*
  self-checking bench for the branch, bit and flag executor.
  assumes the executor, its memory model and bbf_defs.svh are available.
*/
`timescale 1ns/1ps
`include "bbf_defs.svh"

module bbf_exec_tb;
  import bbf_pkg::*;
  // one case: program and state in, next fetch, flags and memory out
  typedef struct {
    logic [10:0] pc;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] dp;
    logic [4:0] ccr;
    logic va;
    logic [3:0] cnt;
    logic [10:0] tgt;
    logic [4:0] eccr;
    logic [7:0] wv;
  } bbf_row_t;

  logic core_clk;
  logic nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  bbf_mem_req_t mem_req;
  logic [7:0] mem_rdata;
  logic irq_req;
  logic irq_ack;
  logic busy;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0;
  // reads and acks seen, stamped with the cycle number
  int rd_cyc[$];
  logic [10:0] rd_adr[$];
  int ack_cyc[$];
  // last apb answer
  logic [31:0] d;
  logic e;
  bbf_row_t r;

  // pc, op, byte2, byte3, direct byte, flags, slow, cycles, fetch, flags out, byte
  // third bytes that a row falls through to hold the filler no-op, so the run-on after a row leaves flags alone
  bbf_row_t rows [16] = '{
  '{11'h100, 8'h2a, 8'h10, 8'h00, 8'h5a, 5'h00, 1'b1, 4'h4, 11'h112, 5'h00, 8'h5a},
  '{11'h100, 8'h2a, 8'h10, 8'h9d, 8'h5a, 5'h04, 1'b0, 4'h3, 11'h102, 5'h04, 8'h5a},
  '{11'h100, 8'h2b, 8'h10, 8'h00, 8'h5a, 5'h04, 1'b0, 4'h3, 11'h112, 5'h04, 8'h5a},
  '{11'h100, 8'h20, 8'h80, 8'h00, 8'h5a, 5'h1f, 1'b1, 4'h4, 11'h082, 5'h1f, 8'h5a},
  '{11'h100, 8'h21, 8'h10, 8'h9d, 8'h5a, 5'h00, 1'b1, 4'h4, 11'h102, 5'h00, 8'h5a},
  '{11'h100, 8'h07, 8'h40, 8'h20, 8'hf7, 5'h1f, 1'b1, 4'ha, 11'h123, 5'h1e, 8'hf7},
  '{11'h100, 8'h01, 8'h40, 8'h20, 8'h01, 5'h0e, 1'b1, 4'ha, 11'h103, 5'h0f, 8'h01},
  '{11'h100, 8'h0e, 8'h40, 8'h05, 8'h80, 5'h00, 1'b0, 4'h5, 11'h108, 5'h01, 8'h80},
  '{11'h100, 8'h00, 8'h40, 8'h05, 8'hfe, 5'h1f, 1'b0, 4'h5, 11'h103, 5'h1e, 8'hfe},
  '{11'h100, 8'h1a, 8'h40, 8'h9d, 8'h00, 5'h15, 1'b1, 4'h7, 11'h102, 5'h15, 8'h20},
  '{11'h100, 8'h10, 8'h40, 8'h9d, 8'h80, 5'h0a, 1'b0, 4'h5, 11'h102, 5'h0a, 8'h81},
  '{11'h100, 8'had, 8'h10, 8'h00, 8'h5a, 5'h00, 1'b1, 4'h8, 11'h112, 5'h00, 8'hf9},
  '{11'h100, 8'had, 8'hf0, 8'h00, 8'h5a, 5'h1f, 1'b0, 4'h6, 11'h0f2, 5'h1f, 8'hf9},
  '{11'h100, 8'h98, 8'h10, 8'h00, 8'h5a, 5'h1f, 1'b0, 4'h2, 11'h101, 5'h1e, 8'h5a},
  '{11'h100, 8'h9a, 8'h10, 8'h00, 8'h5a, 5'h0f, 1'b1, 4'h2, 11'h101, 5'h07, 8'h5a},
  '{11'h7fe, 8'h20, 8'h10, 8'h00, 8'h5a, 5'h00, 1'b0, 4'h3, 11'h010, 5'h00, 8'h5a}
  };

  bbf_exec u_bbf_exec (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .irq_req(irq_req), .irq_ack(irq_ack), .busy(busy)
  );

  bbf_mem_model u_bbf_mem_model (
    .core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata)
  );

  // 100 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // log reads and acks against a running cycle count
  always @(posedge core_clk)
  begin
    if (mem_req.rd === 1'b1)
    begin
      rd_cyc.push_back(cyc);
      rd_adr.push_back(mem_req.addr);
    end
    if (irq_ack === 1'b1)
      ack_cyc.push_back(cyc);
    cyc++;
  end

  // counts every compare, reports a mismatch at once
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; entered just after an edge, leaves one idle cycle
  task automatic apb_xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      give_up("pready wait");
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // a wait that ran out ends the run
  task automatic give_up(input string what);
    check(what, 32'h0, 32'h1);
    wrap_up();
  endtask

  // bounded wait for the sequencer to fall idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40)
      give_up("idle wait");
  endtask

  // load one program, run it, stop at the instruction end and compare
  task automatic run_row(input bbf_row_t c);
    int n;
    logic [10:0] a;
    logic [10:0] seen;
    for (int i = 0; i < 2048; i++)
      u_bbf_mem_model.mem[i] = 8'h9d;
    a = c.pc;
    u_bbf_mem_model.mem[a] = c.op;
    a = a + 11'h001;
    u_bbf_mem_model.mem[a] = c.b1;
    a = a + 11'h001;
    u_bbf_mem_model.mem[a] = c.b2;
    u_bbf_mem_model.mem[11'h040] = c.dp;
    apb_xfer(`BBF_REG_PC, 1'b1, {21'h0, c.pc});
    apb_xfer(`BBF_REG_CCR, 1'b1, {27'h0, c.ccr});
    apb_xfer(`BBF_REG_SP, 1'b1, 32'h7f);
    rd_cyc.delete();
    rd_adr.delete();
    ack_cyc.delete();
    apb_xfer(`BBF_REG_CTRL, 1'b1, {30'h0, c.va, 1'b1});
    n = 0;
    // the log lags the edge by at most one cycle, hence the margin
    while (!(rd_cyc.size() > 0 && cyc > rd_cyc[0] + c.cnt + 1) && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40)
      give_up("run wait");
    apb_xfer(`BBF_REG_CTRL, 1'b1, {30'h0, c.va, 1'b0});
    wait_idle();
    t0 = rd_cyc[0];
    seen = ~c.tgt;
    foreach (rd_cyc[i])
      if (rd_cyc[i] == t0 + c.cnt)
        seen = rd_adr[i];
    check("opcode fetch", {21'h0, rd_adr[0]}, {21'h0, c.pc});
    check("next fetch", {21'h0, seen}, {21'h0, c.tgt});
    apb_xfer(`BBF_REG_CCR, 1'b0, 32'h0);
    check("flags", d, {27'h0, c.eccr});
    apb_xfer(`BBF_REG_SP, 1'b0, 32'h0);
    check("stack pointer", d, (c.op == `BBF_OP_CALL) ? 32'h7d : 32'h7f);
    a = (c.op == `BBF_OP_CALL) ? 11'h07e : 11'h040;
    check("data byte", {24'h0, u_bbf_mem_model.mem[a]}, {24'h0, c.wv});
    a = c.pc + 11'h002;
    if (c.op == `BBF_OP_CALL)
      check("low return", {24'h0, u_bbf_mem_model.mem[11'h07f]}, {24'h0, a[7:0]});
  endtask

  // prints the counts and the verdict, then stops
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_req = 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // reset values and an unmapped place
    apb_xfer(`BBF_REG_PC, 1'b0, 32'h0);
    check("pc reset", d, 32'h0);
    apb_xfer(`BBF_REG_CCR, 1'b0, 32'h0);
    check("flags reset", d, 32'h08);
    apb_xfer(`BBF_REG_SP, 1'b0, 32'h0);
    check("sp reset", d, 32'h7f);
    apb_xfer(12'h020, 1'b0, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", d, 32'h0);
    foreach (rows[i])
      run_row(rows[i]);
    // a request held while masked must stay unanswered
    irq_req <= 1'b1;
    run_row(rows[13]);
    check("masked ack", ack_cyc.size(), 0);
    // clearing the mask lets it through with the next fetch
    r = rows[14];
    r.eccr = 5'h0f;
    run_row(r);
    check("ack count", ack_cyc.size(), 1);
    check("ack cycle", (ack_cyc.size() > 0) ? ack_cyc[0] - t0 : 0, 2);
    irq_req <= 1'b0;
    // a pc write while running is ignored; the loop keeps its place
    u_bbf_mem_model.mem[11'h100] = 8'h20;
    u_bbf_mem_model.mem[11'h101] = 8'hfe;
    apb_xfer(`BBF_REG_PC, 1'b1, 32'h100);
    apb_xfer(`BBF_REG_CTRL, 1'b1, 32'h1);
    apb_xfer(`BBF_REG_STAT, 1'b0, 32'h0);
    check("busy status", d, 32'h1);
    check("busy pin", {31'h0, busy}, 32'h1);
    apb_xfer(`BBF_REG_PC, 1'b1, 32'h555);
    apb_xfer(`BBF_REG_CTRL, 1'b1, 32'h0);
    wait_idle();
    apb_xfer(`BBF_REG_PC, 1'b0, 32'h0);
    check("pc kept", d, 32'h100);
    // a reset in mid-run must stop the loop and restore the reset state
    apb_xfer(`BBF_REG_CTRL, 1'b1, 32'h1);
    repeat (3) @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check("busy after reset", {31'h0, busy}, 32'h0);
    check("fetch after reset", {31'h0, mem_req.rd}, 32'h0);
    check("ack after reset", {31'h0, irq_ack}, 32'h0);
    apb_xfer(`BBF_REG_PC, 1'b0, 32'h0);
    check("pc after reset", d, 32'h0);
    apb_xfer(`BBF_REG_CTRL, 1'b0, 32'h0);
    check("ctrl after reset", d, 32'h0);
    apb_xfer(`BBF_REG_CCR, 1'b0, 32'h0);
    check("flags after reset", d, 32'h08);
    wrap_up();
  end
endmodule

// *** verif/bbf_mem_model.sv ***
/*
  behavioural program and data memory on the executor's memory port.
  assumes the request struct of bbf_pkg, one clock, and a bench that
  preloads the byte array between runs.
*/
`timescale 1ns/1ps
`include "bbf_defs.svh"

module bbf_mem_model (
  input wire logic core_clk,
  input wire bbf_pkg::bbf_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  import bbf_pkg::*;
  // whole address space, one byte a place
  logic [7:0] mem [0:(1<<`BBF_PC_W)-1];
  // last byte handed out, used to scramble the idle bus
  logic [7:0] last_r = 8'h5a;

  // a read answers in its own cycle; with no read asked the bus shows the
  // inverse of the last byte, so a late sample never passes for good data
  always_comb
  begin
    if (mem_req.rd)
      mem_rdata = mem[mem_req.addr];
    else
      mem_rdata = ~last_r;
  end

  // a write lands at the edge that ends its cycle
  always @(posedge core_clk)
  begin
    if (mem_req.rd)
      last_r <= mem[mem_req.addr];
    if (mem_req.wr)
      mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule

// *** verilog/bbf_apb.sv ***
/*
  apb slave for the executor: control, pc, flags, stack pointer, status.
  assumes a standard apb master; answers every access with no wait state.
*/
`timescale 1ns/1ps
`include "bbf_defs.svh"

module bbf_apb (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`BBF_PC_W-1:0] st_pc,
  input wire logic [4:0] st_ccr,
  input wire logic [7:0] st_sp,
  input wire logic st_busy,
  output logic run,
  output logic variant_a,
  output logic ld_pc,
  output logic ld_ccr,
  output logic ld_sp
);
  import bbf_pkg::*;

  logic [1:0] ctrl_r; // run and variant bits
  logic [1:0] ctrl_nxt;
  logic [31:0] rd_nxt; // read word captured in setup phase
  logic hit; // address maps to a register
  logic wr_go; // write takes effect this edge

  // decode and next values
  always_comb
  begin
    hit = 1'b1;
    rd_nxt = prdata;
    case (paddr)
      `BBF_REG_CTRL: rd_nxt = {30'h0, ctrl_r};
      `BBF_REG_PC: rd_nxt = {21'h0, st_pc};
      `BBF_REG_CCR: rd_nxt = {27'h0, st_ccr};
      `BBF_REG_SP: rd_nxt = {24'h0, st_sp};
      `BBF_REG_STAT: rd_nxt = {31'h0, st_busy};
      default:
      begin
        hit = 1'b0;
        rd_nxt = 32'h0;
      end
    endcase
    wr_go = psel && penable && pready && pwrite;
    ctrl_nxt = ctrl_r;
    if (wr_go && paddr == `BBF_REG_CTRL)
    begin
      ctrl_nxt = pwdata[1:0];
    end
  end

  // registers; pready rises for the access phase so no wait states
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= 2'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ld_pc <= 1'b0;
      ld_ccr <= 1'b0;
      ld_sp <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      pready <= psel && !penable;
      if (psel && !penable)
      begin
        prdata <= rd_nxt;
        pslverr <= !hit;
      end
      ld_pc <= wr_go && paddr == `BBF_REG_PC;
      ld_ccr <= wr_go && paddr == `BBF_REG_CCR;
      ld_sp <= wr_go && paddr == `BBF_REG_SP;
    end
  end

  assign run = ctrl_r[`BBF_CTRL_RUN];
  assign variant_a = ctrl_r[`BBF_CTRL_VAR];
endmodule

// *** verilog/bbf_decode.sv ***
/*
  opcode decoder: class, bit index, condition inversion and total cycles.
  assumes the variant input selects the slower (1) or faster (0) timing.
*/
`timescale 1ns/1ps
`include "bbf_defs.svh"

module bbf_decode (
  input wire logic [7:0] opcode,
  input wire logic variant_a,
  output bbf_pkg::bbf_dec_t dec
);
  import bbf_pkg::*;

  // pure lookup, no state
  always_comb
  begin
    dec.cls = CL_NOP;
    dec.bitn = opcode[3:1];
    dec.inv = opcode[0];
    dec.tot = `BBF_CYC_INH;
    if (opcode[7:1] == `BBF_OPH_JREL || opcode[7:1] == `BBF_OPH_JNN)
    begin
      dec.cls = CL_BR;
      dec.tot = variant_a ? `BBF_CYC_BR_A : `BBF_CYC_BR_B;
    end
    else if (opcode[7:4] == `BBF_OPN_TEST)
    begin
      dec.cls = CL_TEST;
      dec.tot = variant_a ? `BBF_CYC_TEST_A : `BBF_CYC_TEST_B;
    end
    else if (opcode[7:4] == `BBF_OPN_SET && !opcode[0])
    begin
      // odd codes in this row are not ours and run as one-byte no-ops
      dec.cls = CL_SET;
      dec.tot = variant_a ? `BBF_CYC_SET_A : `BBF_CYC_SET_B;
    end
    else if (opcode == `BBF_OP_CALL)
    begin
      dec.cls = CL_CALL;
      dec.tot = variant_a ? `BBF_CYC_CALL_A : `BBF_CYC_CALL_B;
    end
    else if (opcode == `BBF_OP_CCLR)
    begin
      dec.cls = CL_CCLR;
    end
    else if (opcode == `BBF_OP_UNMASK)
    begin
      dec.cls = CL_UNMASK;
    end
  end
endmodule

// *** verilog/bbf_defs.svh ***
/*
  constants for the branch, bit and flag instruction executor: opcodes,
  cycle counts, widths, reset values and register offsets.
  assumes it is included by bare name and nothing else defines these names.
*/
`ifndef BBF_DEFS_SVH
`define BBF_DEFS_SVH

// address space and stack placement
`define BBF_PC_W 11
`define BBF_DP_HI 3'h0
`define BBF_STK_HI 3'h0
`define BBF_PCH_FILL 5'h1f
`define BBF_PC_RST 11'h000
`define BBF_SP_RST 8'h7f
`define BBF_CCR_RST 5'h08

// opcodes; pairs differ only in bit 0
`define BBF_OPH_JREL 7'h10
`define BBF_OPH_JNN 7'h15
`define BBF_OP_JREL 8'h20
`define BBF_OP_NOJUMP 8'h21
`define BBF_OP_JNN 8'h2a
`define BBF_OPN_TEST 4'h0
`define BBF_OPN_SET 4'h1
`define BBF_OP_CALL 8'had
`define BBF_OP_CCLR 8'h98
`define BBF_OP_UNMASK 8'h9a

// cycle counts, variant a and variant b
`define BBF_CYC_BR_A 4'h4
`define BBF_CYC_BR_B 4'h3
`define BBF_CYC_TEST_A 4'ha
`define BBF_CYC_TEST_B 4'h5
`define BBF_CYC_SET_A 4'h7
`define BBF_CYC_SET_B 4'h5
`define BBF_CYC_CALL_A 4'h8
`define BBF_CYC_CALL_B 4'h6
`define BBF_CYC_INH 4'h2

// pc step sizes
`define BBF_LEN1 11'h001
`define BBF_LEN2 11'h002
`define BBF_LEN3 11'h003

// apb register byte offsets and control bits
`define BBF_REG_CTRL 12'h000
`define BBF_REG_PC 12'h004
`define BBF_REG_CCR 12'h008
`define BBF_REG_SP 12'h00c
`define BBF_REG_STAT 12'h010
`define BBF_CTRL_RUN 0
`define BBF_CTRL_VAR 1

`endif

// *** verilog/bbf_exec.sv ***
/*
  executor for relative branches, bit test and branch, bit set, relative
  call and the carry / interrupt mask clears, with its apb register slave.
  assumes memory answers a read combinationally in the cycle mem_req.rd is
  high, and takes a write at the edge that ends a cycle with mem_req.wr high.
*/
`timescale 1ns/1ps
`include "bbf_defs.svh"

module bbf_exec (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output bbf_pkg::bbf_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic irq_req,
  output logic irq_ack,
  output logic busy
);
  import bbf_pkg::*;

  localparam int W = `BBF_PC_W;

  bbf_state_t st_r, st_nxt; // sequencer state
  logic [3:0] cnt_r, cnt_nxt; // cycles since the opcode fetch
  logic [W-1:0] pc_r, pc_nxt; // address of the current instruction
  logic [W-1:0] tgt_r, tgt_nxt; // next pc, held while padding
  logic [7:0] sp_r, sp_nxt; // stack pointer
  bbf_flags_t cc_r, cc_nxt; // condition codes
  logic [7:0] op_r, op_nxt; // opcode
  logic [7:0] b2_r, b2_nxt; // second byte
  logic [7:0] opnd_r, opnd_nxt; // direct page operand
  bbf_mem_req_t req_nxt; // next memory request
  logic ack_nxt; // interrupt accept pulse
  bbf_dec_t dec; // decode of the current opcode
  logic [7:0] dec_in; // opcode seen by the decoder
  logic run, variant_a, ld_pc, ld_ccr, ld_sp;
  logic last; // this is the final cycle of the instruction
  logic fin; // work done, leave the rest to padding
  logic taken; // branch condition after inversion
  logic [W-1:0] pc_end; // next pc chosen this cycle
  logic [W-1:0] ret; // return address for the call
  logic [7:0] mask; // one-hot bit for the bit set
  logic [31:0] pwdata_q; // apb write data, one cycle behind the access edge

  // sign-extend and add; the carry out drops so targets wrap
  function automatic logic [W-1:0] rel(input logic [W-1:0] base, input logic [7:0] d);
    rel = base + {{(W-8){d[7]}}, d};
  endfunction

  bbf_decode u_dec (
    .opcode(dec_in),
    .variant_a(variant_a),
    .dec(dec)
  );

  bbf_apb u_apb (
    .core_clk(core_clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .st_pc(pc_r),
    .st_ccr(cc_r),
    .st_sp(sp_r),
    .st_busy(busy),
    .run(run),
    .variant_a(variant_a),
    .ld_pc(ld_pc),
    .ld_ccr(ld_ccr),
    .ld_sp(ld_sp)
  );

  // during the fetch cycle the opcode is still on the memory bus
  assign dec_in = (st_r == ST_FETCH) ? mem_rdata : op_r;
  assign last = (cnt_r == dec.tot - 4'h1);
  assign ret = pc_r + `BBF_LEN2;

  // sequencer: one state per memory cycle, then pad to the cycle count
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 4'h1;
    pc_nxt = pc_r;
    tgt_nxt = tgt_r;
    sp_nxt = sp_r;
    cc_nxt = cc_r;
    op_nxt = op_r;
    b2_nxt = b2_r;
    opnd_nxt = opnd_r;
    req_nxt = '0;
    req_nxt.addr = mem_req.addr;
    ack_nxt = 1'b0;
    fin = 1'b0;
    taken = 1'b0;
    pc_end = pc_r;
    mask = 8'h1 << dec.bitn;
    case (st_r)
      ST_IDLE:
      begin
        cnt_nxt = 4'h0;
        if (run)
        begin
          req_nxt.rd = 1'b1;
          req_nxt.addr = pc_r;
          st_nxt = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        op_nxt = mem_rdata;
        req_nxt.rd = 1'b1;
        req_nxt.addr = pc_r + `BBF_LEN1;
        st_nxt = ST_OP;
      end
      ST_OP:
      begin
        b2_nxt = mem_rdata;
        case (dec.cls)
          CL_BR:
          begin
            // the jump pair tests true, the other pair tests n clear
            taken = ((op_r[7:1] == `BBF_OPH_JREL) ? 1'b1 : !cc_r.n) ^ dec.inv;
            pc_end = taken ? rel(ret, mem_rdata) : ret;
            fin = 1'b1;
          end
          CL_TEST, CL_SET:
          begin
            req_nxt.rd = 1'b1;
            req_nxt.addr = {`BBF_DP_HI, mem_rdata};
            st_nxt = ST_ARG1;
          end
          CL_CALL:
          begin
            // low byte first, at the current stack pointer
            req_nxt.wr = 1'b1;
            req_nxt.addr = {`BBF_STK_HI, sp_r};
            req_nxt.wdata = ret[7:0];
            sp_nxt = sp_r - 8'h1;
            st_nxt = ST_PUSHH;
          end
          CL_CCLR:
          begin
            cc_nxt.c = 1'b0;
            pc_end = pc_r + `BBF_LEN1;
            fin = 1'b1;
          end
          CL_UNMASK:
          begin
            cc_nxt.i = 1'b0;
            pc_end = pc_r + `BBF_LEN1;
            fin = 1'b1;
          end
          default:
          begin
            // opcodes outside this group step over one byte
            pc_end = pc_r + `BBF_LEN1;
            fin = 1'b1;
          end
        endcase
      end
      ST_ARG1:
      begin
        opnd_nxt = mem_rdata;
        if (dec.cls == CL_TEST)
        begin
          cc_nxt.c = mem_rdata[dec.bitn];
          req_nxt.rd = 1'b1;
          req_nxt.addr = pc_r + `BBF_LEN2;
          st_nxt = ST_ARG2;
        end
        else
        begin
          // read-modify-write; flags are left alone
          req_nxt.wr = 1'b1;
          req_nxt.addr = {`BBF_DP_HI, b2_r};
          req_nxt.wdata = mem_rdata | mask;
          pc_end = pc_r + `BBF_LEN2;
          fin = 1'b1;
        end
      end
      ST_ARG2:
      begin
        taken = opnd_r[dec.bitn] ^ dec.inv;
        pc_end = taken ? rel(pc_r + `BBF_LEN3, mem_rdata) : pc_r + `BBF_LEN3;
        fin = 1'b1;
      end
      ST_PUSHH:
      begin
        req_nxt.wr = 1'b1;
        req_nxt.addr = {`BBF_STK_HI, sp_r};
        req_nxt.wdata = {`BBF_PCH_FILL, ret[W-1:8]};
        sp_nxt = sp_r - 8'h1;
        pc_end = rel(ret, b2_r);
        fin = 1'b1;
      end
      ST_WAIT:
        pc_end = tgt_r;
      default:
        st_nxt = ST_IDLE;
    endcase
    if (fin)
    begin
      tgt_nxt = pc_end;
      st_nxt = ST_WAIT;
    end
    // instruction boundary: commit pc, take a pending interrupt, fetch next
    if ((fin || st_r == ST_WAIT) && last)
    begin
      pc_nxt = pc_end;
      cnt_nxt = 4'h0;
      if (irq_req && !cc_nxt.i)
      begin
        ack_nxt = 1'b1;
        cc_nxt.i = 1'b1;
      end
      st_nxt = run ? ST_FETCH : ST_IDLE;
      req_nxt.rd = run;
      req_nxt.addr = pc_nxt;
    end
    // software may load state only while stopped
    if (st_r == ST_IDLE)
    begin
      if (ld_pc)
        pc_nxt = pwdata_q[W-1:0];
      if (ld_ccr)
        cc_nxt = pwdata_q[4:0];
      if (ld_sp)
        sp_nxt = pwdata_q[7:0];
    end
  end

  // apb write data, held one cycle to line up with the load strobes
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pwdata_q <= 32'h0;
    else if (psel && penable && pwrite)
      pwdata_q <= pwdata;
  end

  // state registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      pc_r <= `BBF_PC_RST;
      tgt_r <= `BBF_PC_RST;
      sp_r <= `BBF_SP_RST;
      cc_r <= `BBF_CCR_RST;
      op_r <= 8'h0;
      b2_r <= 8'h0;
      opnd_r <= 8'h0;
      mem_req <= '0;
      irq_ack <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pc_r <= pc_nxt;
      tgt_r <= tgt_nxt;
      sp_r <= sp_nxt;
      cc_r <= cc_nxt;
      op_r <= op_nxt;
      b2_r <= b2_nxt;
      opnd_r <= opnd_nxt;
      mem_req <= req_nxt;
      irq_ack <= ack_nxt;
      busy <= (st_nxt != ST_IDLE);
    end
  end

  chk_jnn_skip: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == ST_OP && op_r == `BBF_OP_JNN && cc_r.n) |=> tgt_r == $past(pc_r) + `BBF_LEN2)
    else $error("negative flag set yet branch taken");
  chk_jrel_target: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == ST_OP && op_r == `BBF_OP_JREL)
    |=> tgt_r == $past(pc_r) + `BBF_LEN2 + {{(W-8){$past(mem_rdata[7])}}, $past(mem_rdata)})
    else $error("always-jump target wrong");
  chk_nojump_len: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == ST_FETCH && mem_rdata == `BBF_OP_NOJUMP && variant_a)
    |=> ##3 (cnt_r == 4'h0 && pc_r == $past(pc_r, 4) + `BBF_LEN2))
    else $error("never-jump not a four-cycle two-byte step");
  chk_test_carry: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == ST_ARG1 && dec.cls == CL_TEST)
    |=> (cc_r.c == $past(mem_rdata[dec.bitn]) && cc_r[4:1] == $past(cc_r[4:1])))
    else $error("bit test carry or other flags wrong");
  chk_set_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == ST_ARG1 && dec.cls == CL_SET) |=> (mem_req.wr && cc_r == $past(cc_r)
      && mem_req.wdata == ($past(mem_rdata) | (8'h1 << $past(op_r[3:1])))))
    else $error("bit set wrote wrong value or touched flags");
  chk_call_push: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == ST_OP && dec.cls == CL_CALL)
    |=> mem_req.wr ##1 (mem_req.wr && sp_r == $past(sp_r, 2) - 8'h2))
    else $error("call pushes or stack pointer wrong");
  chk_call_fill: assert property (@(posedge core_clk) disable iff (!nrst)
    st_r == ST_PUSHH |=> mem_req.wdata[7:W-8] == `BBF_PCH_FILL)
    else $error("unused return bits not ones");
  chk_cclr_only: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == ST_OP && dec.cls == CL_CCLR)
    |=> (!cc_r.c && cc_r.h == $past(cc_r.h) && cc_r.n == $past(cc_r.n) && cc_r.z == $past(cc_r.z)))
    else $error("carry clear disturbed other flags");
  chk_unmask_irq: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == ST_OP && dec.cls == CL_UNMASK && irq_req) |=> irq_ack)
    else $error("pending interrupt not taken after unmask");
endmodule

// *** verilog/bbf_pkg.sv ***
/*
  types shared by the executor, its decoder and its register slave.
  assumes bbf_defs.svh is on the include path.
*/
`include "bbf_defs.svh"

package bbf_pkg;
  // instruction classes handled here
  typedef enum logic [2:0] {CL_NOP, CL_BR, CL_TEST, CL_SET, CL_CALL, CL_CCLR, CL_UNMASK}
    bbf_cls_t;
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_OP, ST_ARG1, ST_ARG2, ST_PUSHH, ST_WAIT}
    bbf_state_t;
  // condition code flags
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } bbf_flags_t;
  // decoded opcode
  typedef struct packed {
    bbf_cls_t cls;
    logic [2:0] bitn;
    logic inv;
    logic [3:0] tot;
  } bbf_dec_t;
  // memory request toward program and data memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`BBF_PC_W-1:0] addr;
    logic [7:0] wdata;
  } bbf_mem_req_t;
endpackage
